// ===== design/frame_rx_pkg.sv
// Constants shared by the timing command frame receiver
package frame_rx_pkg;
   localparam int CLK_PERIOD_PS = 4000;
   localparam int BUNCH_PERIOD_PS = 25000;
   localparam int BUNCH_CYC_RAW = BUNCH_PERIOD_PS / CLK_PERIOD_PS;
   localparam int BUNCH_CYC = (BUNCH_CYC_RAW < 1) ? 1 : BUNCH_CYC_RAW;
   localparam int TICK_W = 3;
   localparam logic [4:0] ONES_LIMIT = 5'h17;
   localparam int BC_BITS = 13;
   localparam int AD_BITS = 39;
   localparam int BC_CMD_W = 8;
   localparam int BC_CHK_W = 5;
   localparam int AD_DATA_W = 32;
   localparam int AD_CHK_W = 7;
   localparam int AD_ADDR_W = 14;
   localparam int AD_ADDR_LSB = 18;
   localparam int AD_SEL_BIT = 17;
   localparam int AD_FIXED_BIT = 16;
   localparam int AD_SUB_LSB = 8;
   localparam int BC_BUNCH_RST_BIT = 0;
   localparam int BC_EVENT_RST_BIT = 1;
   localparam int CDLY_DEPTH = 16;
   localparam int NREG = 10;
   localparam logic [3:0] IDX_FINE_A = 4'h0;
   localparam logic [3:0] IDX_FINE_B = 4'h1;
   localparam logic [3:0] IDX_COARSE = 4'h2;
   localparam logic [3:0] IDX_CTRL = 4'h3;
   localparam logic [3:0] IDX_ID0 = 4'h4;
   localparam logic [3:0] IDX_ID1 = 4'h5;
   localparam logic [3:0] IDX_ID2 = 4'h6;
   localparam logic [3:0] IDX_CFG1 = 4'h7;
   localparam logic [7:0] RESET_VAL [NREG] = '{8'h00, 8'h00, 8'h00, 8'h93,
      8'h00, 8'h00, 8'h00, 8'h02, 8'h84, 8'hA7};
   localparam int CTL_BUNCH_EN = 0;
   localparam int CTL_EVENT_EN = 1;
   localparam int CTL_PAR_EN = 5;
   localparam int CFG1_EVT_BUS = 0;
   localparam logic [4:0] A_TIMING_TOP = 5'h03;
   localparam logic [4:0] A_SGL_LO = 5'h08;
   localparam logic [4:0] A_SGL_HI = 5'h09;
   localparam logic [4:0] A_DBL = 5'h0A;
   localparam logic [4:0] A_UPS = 5'h0B;
   localparam logic [4:0] A_ID_BASE = 5'h10;
   localparam logic [4:0] A_ID_TOP = 5'h15;
   localparam logic [4:0] A_STATUS = 5'h16;
   localparam logic [4:0] A_BUNCH_LO = 5'h18;
   localparam logic [4:0] A_BUNCH_HI = 5'h19;
   localparam logic [4:0] A_EVT0 = 5'h1A;
   localparam logic [4:0] A_EVT1 = 5'h1B;
   localparam logic [4:0] A_EVT2 = 5'h1C;
   localparam logic [7:0] SUB_REG_TOP = 8'h03;
   localparam logic [7:0] SUB_ERR_DUMP = 8'h08;
   localparam logic [3:0] QUAL_ADDR = 4'h0;
   localparam logic [3:0] QUAL_DUMP = 4'h1;
   localparam logic [2:0] DUMP_LEN = 3'h4;
   localparam logic [6:0] PROM_BITS = 7'h50;
   localparam logic [1:0] BOOT_SAMPLE = 2'h2;
endpackage : frame_rx_pkg

// ===== design/secded_decode.sv
// Hamming single-correct double-detect decoder with overall parity
`timescale 1ns/1ps
module secded_decode #(
   parameter int K = 8,
   parameter int P = 5
) (
   input wire logic [K-1:0] data_in,
   input wire logic [P-1:0] check_in,
   output logic [K-1:0] data_out,
   output logic single_err,
   output logic double_err
);
   // Codeword position of data bit i, skipping powers of two
   function automatic int data_pos(input int i);
      int pos;
      int n;
      pos = 2;
      n = -1;
      while (n < i) begin
         pos++;
         if ((pos & (pos - 1)) != 0) n++;
      end
      return pos;
   endfunction : data_pos

   logic [P-2:0] syn;
   logic par;
   logic hit;

   always_comb begin
      syn = check_in[P-2:0];
      par = ^{data_in, check_in};
      hit = 1'b0;
      data_out = data_in;
      for (int i = 0; i < K; i++) begin
         if (data_in[i]) syn = syn ^ (P-1)'(data_pos(i));
      end
      for (int i = 0; i < K; i++) begin
         if (par && syn == (P-1)'(data_pos(i))) begin
            data_out[i] = ~data_in[i];
            hit = 1'b1;
         end
      end
      // Odd parity with a syndrome off the code is not correctable
      single_err = par && (hit || $onehot0(syn));
      double_err = (!par && syn != '0) || (par && !(hit || $onehot0(syn)));
   end
endmodule : secded_decode

// ===== design/coarse_delay_line.sv
// Coarse delay pipeline stepped once per bunch period
`timescale 1ns/1ps
module coarse_delay_line #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic step,
   input wire logic [$clog2(DEPTH)-1:0] depth_sel,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] stage_q [DEPTH];

   always_ff @(posedge clock) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) stage_q[i] <= '0;
      end else if (step) begin
         stage_q[0] <= din;
         for (int i = 1; i < DEPTH; i++) stage_q[i] <= stage_q[i-1];
      end
   end

   // Zero depth passes straight through in the same bunch
   assign dout = (depth_sel == '0) ? din : stage_q[depth_sel - 1'b1];
endmodule : coarse_delay_line

// ===== design/timing_command_frame_receiver.sv
// Trigger and command channel receiver with deframing and counters
`timescale 1ns/1ps
module timing_command_frame_receiver
   import frame_rx_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [1:0] stream_pair,
   input wire logic prom_mode,
   input wire logic prom_data,
   output logic prom_clk,
   input wire logic mgmt_wr,
   input wire logic [4:0] mgmt_addr,
   input wire logic [7:0] mgmt_wdata,
   output logic [7:0] mgmt_rdata,
   output logic trigger_accept,
   output logic bcast_strobe_low,
   output logic bcast_strobe_high,
   output logic [7:2] bcast_cmd,
   output logic bunch_reset_pulse,
   output logic event_reset_pulse,
   output logic [11:0] count_out_bus,
   output logic [7:0] ext_bus_a,
   output logic [7:0] ext_bus_d,
   output logic [3:0] ext_qual,
   output logic ext_data_strobe,
   output logic [7:0] fine_delay_a,
   output logic [7:0] fine_delay_b,
   output logic [5:0] mgmt_bus_id
);
   typedef enum logic [1:0] {S_IDLE, S_FMT, S_BODY, S_STOP} rx_state_t;

   function automatic logic [7:0] maj(input logic [7:0] a, b, c);
      return (a & b) | (a & c) | (b & c);
   endfunction : maj

   // Management address to register index, top bit marks a hit
   function automatic logic [4:0] addr_idx(input logic [4:0] a);
      if (a <= A_TIMING_TOP) return {1'b1, a[3:0]};
      if (a >= A_ID_BASE && a <= A_ID_TOP)
         return {1'b1, 4'(a - A_ID_BASE + 5'(IDX_ID0))};
      return 5'h00;
   endfunction : addr_idx

   logic [TICK_W-1:0] tick_q;
   logic [1:0] pair_s1_q, pair_s2_q;
   logic prom_s1_q, prom_s2_q, mode_s1_q, mode_s2_q;
   logic slot_q;
   logic [4:0] run_q [2];
   rx_state_t st_q;
   logic fmt_q;
   logic [5:0] cnt_q;
   logic [AD_BITS-1:0] sh_q;
   logic [7:0] copy_q [3][NREG];
   logic [7:0] voted [NREG];
   logic [3:0] sc_idx_q;
   logic [11:0] bunch_q;
   logic [23:0] event_q;
   logic [1:0] seq_q;
   logic [15:0] sgl_q;
   logic [7:0] dbl_q, ups_q;
   logic [2:0] dump_cnt_q;
   logic [1:0] boot_q, ld_ph_q;
   logic ld_busy_q;
   logic [6:0] ld_bit_q;
   logic [7:0] ld_sh_q;
   logic [7:0] rd_byte, dump_byte;
   logic [BC_CMD_W-1:0] bc_cmd;
   logic [AD_DATA_W-1:0] ad_fix;
   logic bc_sgl, bc_dbl, ad_sgl, ad_dbl;
   logic [7:0] lo_out;
   logic [2:0] hi_out;

   wire tick = tick_q == TICK_W'(BUNCH_CYC - 1);
   wire a_bit = pair_s2_q[slot_q];
   wire b_bit = pair_s2_q[~slot_q];
   wire swap = tick && a_bit && run_q[slot_q] == ONES_LIMIT;
   wire trig_raw = tick && a_bit && !swap;
   wire [7:0] ctrl = voted[IDX_CTRL];
   wire bunch_en = ctrl[CTL_BUNCH_EN];
   wire ev_en = ctrl[CTL_EVENT_EN];
   wire par_en = ctrl[CTL_PAR_EN];
   wire evt_bus = voted[IDX_CFG1][CFG1_EVT_BUS] && ev_en;
   wire [13:0] chip_id = {voted[IDX_ID1][5:0], voted[IDX_ID0]};

   always_ff @(posedge clock) begin
      if (reset) begin
         tick_q <= '0;
         pair_s1_q <= '0;
         pair_s2_q <= '0;
         {prom_s1_q, prom_s2_q, mode_s1_q, mode_s2_q} <= '0;
      end else begin
         tick_q <= tick ? '0 : tick_q + 1'b1;
         pair_s1_q <= stream_pair;
         pair_s2_q <= pair_s1_q;
         {prom_s1_q, mode_s1_q} <= {prom_data, prom_mode};
         {prom_s2_q, mode_s2_q} <= {prom_s1_q, mode_s1_q};
      end
   end

   // Channel lock: a run beyond the limit marks the command slot
   always_ff @(posedge clock) begin
      if (reset) begin
         slot_q <= 1'b0;
         run_q[0] <= '0;
         run_q[1] <= '0;
      end else if (tick) begin
         slot_q <= slot_q ^ swap;
         for (int s = 0; s < 2; s++) begin
            if (!pair_s2_q[s] || swap) run_q[s] <= '0;
            else if (run_q[s] != ONES_LIMIT) run_q[s] <= run_q[s] + 5'h01;
         end
      end
   end

   wire [5:0] last_bit = fmt_q ? 6'(AD_BITS - 1) : 6'(BC_BITS - 1);

   always_ff @(posedge clock) begin
      if (reset) begin
         st_q <= S_IDLE;
         fmt_q <= 1'b0;
         cnt_q <= '0;
         sh_q <= '0;
      end else if (tick) begin
         case (st_q)
            S_IDLE: if (!b_bit) st_q <= S_FMT;
            S_FMT: begin
               fmt_q <= b_bit;
               cnt_q <= '0;
               st_q <= S_BODY;
            end
            S_BODY: begin
               sh_q <= {sh_q[AD_BITS-2:0], b_bit};
               cnt_q <= cnt_q + 6'h01;
               if (cnt_q == last_bit) st_q <= S_STOP;
            end
            S_STOP: st_q <= S_IDLE;
            default: st_q <= S_IDLE;
         endcase
      end
   end

   secded_decode #(.K(BC_CMD_W), .P(BC_CHK_W)) u_bc_dec (
      .data_in(sh_q[BC_BITS-1:BC_CHK_W]),
      .check_in(sh_q[BC_CHK_W-1:0]),
      .data_out(bc_cmd),
      .single_err(bc_sgl),
      .double_err(bc_dbl)
   );

   secded_decode #(.K(AD_DATA_W), .P(AD_CHK_W)) u_ad_dec (
      .data_in(sh_q[AD_BITS-1:AD_CHK_W]),
      .check_in(sh_q[AD_CHK_W-1:0]),
      .data_out(ad_fix),
      .single_err(ad_sgl),
      .double_err(ad_dbl)
   );

   wire frame_end = tick && st_q == S_STOP;
   wire f_sgl = fmt_q ? ad_sgl : bc_sgl;
   wire f_dbl = fmt_q ? (ad_dbl || !ad_fix[AD_FIXED_BIT]) : bc_dbl;
   wire frame_bad = frame_end && (!b_bit || f_dbl);
   wire frame_good = frame_end && !frame_bad;
   wire single_hit = frame_good && f_sgl;
   wire bc_go = frame_good && !fmt_q;
   wire [13:0] ad_addr = ad_fix[AD_DATA_W-1:AD_ADDR_LSB];
   wire ad_go = frame_good && fmt_q && (ad_addr == chip_id || ad_addr == '0);
   wire ad_ext = ad_go && ad_fix[AD_SEL_BIT];
   wire ad_int = ad_go && !ad_fix[AD_SEL_BIT];
   wire [7:0] ad_sub = ad_fix[AD_SUB_LSB +: 8];
   wire [7:0] ad_data = ad_fix[7:0];
   wire lk_wr = ad_int && ad_sub <= SUB_REG_TOP;
   wire dump_go = ad_int && ad_sub == SUB_ERR_DUMP && par_en;

   // Trigger, low strobe, its command bits and counter resets share delay 1
   wire [7:0] lo_in = {trig_raw, bc_go, bc_cmd[5:2] & {4{bc_go}},
      bc_go & bc_cmd[BC_EVENT_RST_BIT], bc_go & bc_cmd[BC_BUNCH_RST_BIT]};
   wire [2:0] hi_in = {bc_go, bc_cmd[7:6] & {2{bc_go}}};

   coarse_delay_line #(.W(8), .DEPTH(CDLY_DEPTH)) u_dly_lo (
      .clock(clock),
      .reset(reset),
      .step(tick),
      .depth_sel(voted[IDX_COARSE][3:0]),
      .din(lo_in),
      .dout(lo_out)
   );

   coarse_delay_line #(.W(3), .DEPTH(CDLY_DEPTH)) u_dly_hi (
      .clock(clock),
      .reset(reset),
      .step(tick),
      .depth_sel(voted[IDX_COARSE][7:4]),
      .din(hi_in),
      .dout(hi_out)
   );

   wire d_trig = tick && lo_out[7];
   wire d_eres = tick && lo_out[1];
   wire d_bres = tick && lo_out[0];

   always_ff @(posedge clock) begin
      if (reset) begin
         {trigger_accept, bcast_strobe_low, bcast_strobe_high} <= '0;
         {bunch_reset_pulse, event_reset_pulse} <= '0;
         bcast_cmd <= '0;
      end else begin
         trigger_accept <= d_trig;
         bcast_strobe_low <= tick && lo_out[6];
         bcast_strobe_high <= tick && hi_out[2];
         bunch_reset_pulse <= d_bres;
         event_reset_pulse <= d_eres;
         if (tick && lo_out[6]) bcast_cmd[5:2] <= lo_out[5:2];
         if (tick && hi_out[2]) bcast_cmd[7:6] <= hi_out[1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         bunch_q <= '0;
         event_q <= '0;
         seq_q <= '0;
         count_out_bus <= '0;
      end else begin
         if (d_bres) bunch_q <= '0;
         else if (tick && bunch_en) bunch_q <= bunch_q + 12'h001;
         if (d_eres) event_q <= '0;
         else if (d_trig && ev_en) event_q <= event_q + 24'h00_0001;
         if (tick) begin
            seq_q <= d_trig ? 2'h1 : (seq_q == 2'h1 ? 2'h2 : 2'h0);
            if (!bunch_en) count_out_bus <= '0;
            else if (evt_bus && seq_q == 2'h1) count_out_bus <= event_q[11:0];
            else if (evt_bus && seq_q == 2'h2) count_out_bus <= event_q[23:12];
            else count_out_bus <= bunch_q;
         end
      end
   end

   // Register file: three voted copies, one shared write port
   wire ld_wr = ld_busy_q && ld_ph_q == 2'h3 && ld_bit_q[2:0] == 3'h7;
   wire [7:0] ld_byte = {ld_sh_q[6:0], prom_s2_q};
   wire [4:0] mg_map = addr_idx(mgmt_addr);
   wire mg_reg_wr = mgmt_wr && mg_map[4];
   wire mism = copy_q[0][sc_idx_q] != copy_q[1][sc_idx_q]
      || copy_q[0][sc_idx_q] != copy_q[2][sc_idx_q];
   wire sc_fix = mism && !(ld_wr || mg_reg_wr || lk_wr);
   wire wr_en = ld_wr || mg_reg_wr || lk_wr || sc_fix;
   wire [3:0] wr_idx = ld_wr ? ld_bit_q[6:3] : mg_reg_wr ? mg_map[3:0]
      : lk_wr ? ad_sub[3:0] : sc_idx_q;
   wire [7:0] wr_dat = ld_wr ? ld_byte : mg_reg_wr ? mgmt_wdata
      : lk_wr ? ad_data : voted[sc_idx_q];

   always_comb begin
      for (int i = 0; i < NREG; i++)
         voted[i] = maj(copy_q[0][i], copy_q[1][i], copy_q[2][i]);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         for (int c = 0; c < 3; c++)
            for (int i = 0; i < NREG; i++) copy_q[c][i] <= RESET_VAL[i];
         sc_idx_q <= '0;
      end else begin
         if (wr_en)
            for (int c = 0; c < 3; c++) copy_q[c][wr_idx] <= wr_dat;
         sc_idx_q <= (sc_idx_q == 4'(NREG - 1)) ? '0 : sc_idx_q + 4'h1;
      end
   end

   // Error counters; an event in the clearing cycle still counts
   wire clr_sgl = mgmt_wr && (mgmt_addr == A_SGL_LO || mgmt_addr == A_SGL_HI);
   wire clr_dbl = mgmt_wr && mgmt_addr == A_DBL;
   wire clr_ups = mgmt_wr && mgmt_addr == A_UPS;

   always_ff @(posedge clock) begin
      if (reset) begin
         sgl_q <= '0;
         dbl_q <= '0;
         ups_q <= '0;
      end else begin
         sgl_q <= (clr_sgl ? '0 : sgl_q) + 16'(single_hit);
         dbl_q <= (clr_dbl ? '0 : dbl_q) + 8'(frame_bad);
         ups_q <= (clr_ups ? '0 : ups_q) + 8'(sc_fix);
      end
   end

   wire [2:0] dump_idx = DUMP_LEN - dump_cnt_q;
   always_comb begin
      case (dump_idx)
         3'h0: dump_byte = sgl_q[7:0];
         3'h1: dump_byte = sgl_q[15:8];
         3'h2: dump_byte = dbl_q;
         default: dump_byte = ups_q;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         dump_cnt_q <= '0;
         {ext_bus_a, ext_bus_d, ext_qual} <= '0;
         ext_data_strobe <= 1'b0;
      end else begin
         if (dump_go) dump_cnt_q <= DUMP_LEN;
         else if (dump_cnt_q != '0) dump_cnt_q <= dump_cnt_q - 3'h1;
         ext_data_strobe <= 1'b0;
         if (dump_cnt_q != '0) begin
            ext_bus_a <= {5'h00, dump_idx};
            ext_bus_d <= dump_byte;
            ext_qual <= QUAL_DUMP;
            ext_data_strobe <= 1'b1;
         end else if (ad_ext && par_en) begin
            ext_bus_a <= ad_sub;
            ext_bus_d <= ad_data;
            ext_qual <= QUAL_ADDR;
            ext_data_strobe <= 1'b1;
         end
      end
   end

   // Loader: strap read once, a few edges after release
   always_ff @(posedge clock) begin
      if (reset) begin
         {boot_q, ld_ph_q, ld_bit_q, ld_sh_q} <= '0;
         ld_busy_q <= 1'b0;
         prom_clk <= 1'b0;
      end else begin
         if (boot_q != 2'h3) boot_q <= boot_q + 2'h1;
         if (boot_q == BOOT_SAMPLE) ld_busy_q <= mode_s2_q;
         else if (ld_busy_q) begin
            ld_ph_q <= ld_ph_q + 2'h1;
            if (ld_ph_q == 2'h3) begin
               ld_sh_q <= ld_byte;
               ld_bit_q <= ld_bit_q + 7'h01;
               if (ld_bit_q == PROM_BITS - 7'h01) ld_busy_q <= 1'b0;
            end
         end
         prom_clk <= ld_busy_q && ld_ph_q == 2'h0;
      end
   end

   always_comb begin
      case (mgmt_addr)
         A_SGL_LO: rd_byte = sgl_q[7:0];
         A_SGL_HI: rd_byte = sgl_q[15:8];
         A_DBL: rd_byte = dbl_q;
         A_UPS: rd_byte = ups_q;
         A_STATUS: rd_byte = {6'h00, ld_busy_q, slot_q};
         A_BUNCH_LO: rd_byte = bunch_q[7:0];
         A_BUNCH_HI: rd_byte = {4'h0, bunch_q[11:8]};
         A_EVT0: rd_byte = event_q[7:0];
         A_EVT1: rd_byte = event_q[15:8];
         A_EVT2: rd_byte = event_q[23:16];
         default: rd_byte = mg_map[4] ? voted[mg_map[3:0]] : 8'h00;
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) mgmt_rdata <= '0;
      else mgmt_rdata <= rd_byte;
   end

   assign fine_delay_a = voted[IDX_FINE_A];
   assign fine_delay_b = voted[IDX_FINE_B];
   assign mgmt_bus_id = voted[IDX_ID2][5:0];

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   AST_CHAN_SWAP: assert property (swap |=> slot_q != $past(slot_q))
      else $error("channel slot did not swap");
   AST_BUNCH_STEP: assert property (tick && bunch_en && !d_bres
      |=> bunch_q == $past(bunch_q) + 12'h001)
      else $error("bunch counter did not advance");
   AST_EVENT_STEP: assert property (d_trig && ev_en && !d_eres
      |=> event_q == $past(event_q) + 24'h00_0001)
      else $error("event counter did not advance");
   AST_SINGLE_COUNT: assert property (single_hit && !clr_sgl
      |=> sgl_q == $past(sgl_q) + 16'h0001)
      else $error("single error not counted");
   AST_BAD_FRAME: assert property (frame_bad && !clr_dbl
      |=> dbl_q == $past(dbl_q) + 8'h01 && !ext_data_strobe)
      else $error("bad frame not counted or acted on");
   AST_NO_BAD_EXEC: assert property (frame_bad |-> !bc_go && !ad_go)
      else $error("bad frame executed");
   AST_EXT_QUAL: assert property (ad_ext && par_en && dump_cnt_q == '0
      |=> ext_data_strobe && ext_qual == QUAL_ADDR && ext_bus_a == $past(ad_sub))
      else $error("external frame not presented");
   AST_DUMP_SEQ: assert property (dump_go
      |=> ##1 (ext_data_strobe && ext_qual == QUAL_DUMP)[*4])
      else $error("error dump sequence wrong");
   AST_UPSET_COUNT: assert property (sc_fix && !clr_ups
      |=> ups_q == $past(ups_q) + 8'h01 && !mism)
      else $error("upset not corrected or counted");
   AST_LOADER_START: assert property ($rose(ld_busy_q)
      |-> $past(boot_q) == BOOT_SAMPLE && $past(mode_s2_q))
      else $error("loader started outside boot");
   AST_EVENT_BUS: assert property (d_trig && evt_bus && bunch_en
      |=> ##[1:6] (tick && seq_q == 2'h1) ##1 count_out_bus == event_q[11:0])
      else $error("event number not shown on count bus");
endmodule : timing_command_frame_receiver

// ===== tb/link_tx_model.sv
// Transmitter model driving the trigger and command slots
`timescale 1ns/1ps
module link_tx_model (
   input wire logic clock,
   input wire logic reset,
   output logic [1:0] stream_pair
);
   logic q_cmd[$];
   logic q_trig[$];
   int cnt = 0;
   time trig_t = 0;
   initial stream_pair = 2'b10;
   always @(posedge clock) begin
      cnt <= (reset || cnt == 5) ? 0 : cnt + 1;
   end
   // New pair once per bunch, well clear of the sampling tick
   always @(negedge clock) begin
      if (!reset && cnt == 0) begin
         if (q_trig.size() > 0 && q_trig[0]) trig_t <= $time;
         // Idle command slot stays high between frames
         stream_pair[1] <= q_cmd.size() > 0 ? q_cmd.pop_front() : 1'b1;
         // Triggers are always spaced, never a long run of ones
         stream_pair[0] <= q_trig.size() > 0 ? q_trig.pop_front() : 1'b0;
      end
   end
endmodule : link_tx_model

// ===== tb/tb_timing_command_frame_receiver.sv
// Self-checking bench for the timing command frame receiver
`timescale 1ns/1ps
module tb_timing_command_frame_receiver;
   import frame_rx_pkg::*;
   logic clock = 0, reset = 1, mgmt_wr = 0, prom_clk, trigger_accept;
   logic bcast_strobe_low, bcast_strobe_high, bunch_reset_pulse;
   logic event_reset_pulse, ext_data_strobe;
   logic [1:0] stream_pair;
   logic [4:0] mgmt_addr = '0;
   logic [7:0] mgmt_wdata = '0, mgmt_rdata, ext_bus_a, ext_bus_d, v;
   logic [7:0] fine_delay_a, fine_delay_b, cmd, sub, dat;
   logic [7:2] bcast_cmd;
   logic [11:0] count_out_bus;
   logic [3:0] ext_qual, dn;
   logic [5:0] mgmt_bus_id, lq[$];
   logic [1:0] hq[$];
   logic [19:0] xq[$];
   int fail_count = 0, n_tests = 0, n_sgl = 0, n_dbl = 0, n_trig = 0, n;
   time trig_at, t0;
   timing_command_frame_receiver u_timing_command_frame_receiver (
      .clock, .reset, .stream_pair, .prom_mode(1'b0), .prom_data(1'b0),
      .prom_clk(), .mgmt_wr, .mgmt_addr, .mgmt_wdata, .mgmt_rdata,
      .trigger_accept, .bcast_strobe_low, .bcast_strobe_high, .bcast_cmd,
      .bunch_reset_pulse, .event_reset_pulse, .count_out_bus, .ext_bus_a,
      .ext_bus_d, .ext_qual, .ext_data_strobe, .fine_delay_a(),
      .fine_delay_b(), .mgmt_bus_id());
   link_tx_model u_link_tx_model (.clock, .reset, .stream_pair);
   always #2 clock = ~clock;
   // Sampled mid-cycle, clear of the edge that launches the outputs
   always @(negedge clock) begin
      if (bcast_strobe_high) hq.push_back(bcast_cmd[7:6]);
      if (bcast_strobe_low)
         lq.push_back({event_reset_pulse, bunch_reset_pulse, bcast_cmd[5:2]});
      if (ext_data_strobe) xq.push_back({ext_qual, ext_bus_a, ext_bus_d});
      if (trigger_accept) begin
         n_trig++;
         trig_at = $time;
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude
   // Hamming positions skip powers of two, top bit is overall parity
   function automatic logic [6:0] chk(logic [31:0] d, int k, int p);
      logic [6:0] c;
      int pos;
      logic par;
      c = '0;
      pos = 2;
      par = 0;
      for (int i = 0; i < k; i++) begin
         pos++;
         if ((pos & (pos - 1)) == 0) pos++;
         for (int j = 0; j < p - 1; j++) if (pos[j]) c[j] ^= d[i];
         par ^= d[i];
      end
      c[p-1] = par ^ (^c);
      return c;
   endfunction : chk
   // Whole frame, MSB first, optional bit flips and bad stop
   task automatic send(logic fmt, logic [31:0] pay, int f1, int f2, logic s);
      logic b[$];
      logic [6:0] c;
      int k;
      int p;
      k = fmt ? 32 : 8;
      p = fmt ? 7 : 5;
      c = chk(pay, k, p);
      for (int i = k - 1; i >= 0; i--) b.push_back(pay[i]);
      for (int j = p - 1; j >= 0; j--) b.push_back(c[j]);
      if (f1 >= 0) b[f1] = !b[f1];
      if (f2 >= 0) b[f2] = !b[f2];
      b.push_front(fmt);
      b.push_front(1'b0);
      b.push_back(s);
      foreach (b[i]) u_link_tx_model.q_cmd.push_back(b[i]);
      while (u_link_tx_model.q_cmd.size() + u_link_tx_model.q_trig.size())
         @(negedge clock);
      // Room for the longest coarse delay and a dump
      repeat (120) @(negedge clock);
   endtask : send
   task automatic rd(logic [4:0] a, output logic [7:0] r);
      @(negedge clock) mgmt_addr = a;
      @(negedge clock) r = mgmt_rdata;
   endtask : rd
   initial begin
      #200us;
      fail_count++;
      conclude();
   end
   initial begin
      void'($urandom(32'hb690));
      repeat (10) @(negedge clock);
      reset = 0;
      rd(5'h03, v);
      check("control", v, 8'h93);
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         cmd = $urandom;
         n = $urandom_range(12, 0);
         send(0, cmd, (m == 1 || m == 2) ? n : -1, m == 2 ? (n + 1) % 13 : -1,
            m != 3);
         if (m < 2) check("command", lq.pop_front(), {cmd[1:0], cmd[5:2]});
         if (m < 2) check("upper", hq.pop_front(), cmd[7:6]);
         check("leftover", lq.size(), 0);
         lq.delete();
         hq.delete();
         n_sgl += (m == 1);
         n_dbl += (m >= 2);
      end
      rd(A_SGL_LO, v);
      check("single count", v, n_sgl);
      rd(A_DBL, v);
      check("double count", v, n_dbl);
      $display("test broadcast done");
      @(negedge clock) {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, 5'h03, 8'hB3};
      @(negedge clock) mgmt_wr = 0;
      send(0, 8'h02, -1, -1, 1);
      n = $urandom_range(9, 1);
      n_trig = 0;
      repeat (n) begin
         u_link_tx_model.q_trig.push_back(1'b1);
         u_link_tx_model.q_trig.push_back(1'b0);
      end
      send(0, 8'h00, -1, -1, 1);
      check("triggers", n_trig, n);
      rd(A_EVT0, v);
      check("event count", v, n);
      t0 = trig_at - u_link_tx_model.trig_t;
      dn = $urandom_range(15, 1);
      send(1, {16'h0001, 8'h02, 4'h0, dn}, -1, -1, 1);
      rd(5'h02, v);
      check("coarse", v, dn);
      u_link_tx_model.q_trig.push_back(1'b1);
      send(0, 8'h00, -1, -1, 1);
      check("delay", trig_at - u_link_tx_model.trig_t - t0, dn * 24);
      $display("test trigger done");
      sub = $urandom;
      dat = $urandom;
      send(1, {16'h0003, sub, dat}, $urandom_range(38, 0), -1, 1);
      n_sgl++;
      check("external", xq.pop_front(), {QUAL_ADDR, sub, dat});
      send(1, {14'h1234, 2'b11, sub, dat}, -1, -1, 1);
      check("foreign", xq.size(), 0);
      send(1, {16'h0001, SUB_ERR_DUMP, 8'h00}, -1, -1, 1);
      for (int i = 0; i < 4; i++)
         check("dump", xq.pop_front(), {QUAL_DUMP, 8'(i), i == 0 ? 8'(n_sgl) :
            i == 2 ? 8'(n_dbl) : 8'h00});
      $display("test addressed done");
      conclude();
   end
endmodule : tb_timing_command_frame_receiver
